// *** verilog/lseb_pkg.sv ***
// Constants, register map and state encoding of the LED sink enable and brightness block.
// Assumes a single 250 MHz clock and a two-wire serial register port on pins.
package lseb_pkg;

   // Serial port: seven-bit chip address of this device
   localparam logic [6:0] LSEB_CHIP_ADDR   = 7'h36;

   // Register addresses
   localparam logic [7:0] LSEB_GP_ADDR     = 8'h10;
   localparam logic [7:0] LSEB_MAIN_ADDR   = 8'ha0;
   localparam logic [7:0] LSEB_SEC_ADDR    = 8'h80;

   // Reset values
   localparam logic [7:0] LSEB_GP_RESET    = 8'hc0;
   localparam logic [7:0] LSEB_LEVEL_RESET = 8'h80;
   localparam logic [7:0] LSEB_UNMAPPED    = 8'h00;

   // General purpose register fields
   localparam int         LSEB_MAIN_ON_BIT   = 0;
   localparam int         LSEB_SEC_ON_BIT    = 1;
   localparam int         LSEB_SHARED_BIT    = 2;
   localparam int         LSEB_RAMP_LOW_BIT  = 3;
   localparam int         LSEB_RAMP_HIGH_BIT = 4;
   localparam int         LSEB_DISPLAY_BIT   = 5;
   localparam logic [7:0] LSEB_GP_FIXED_ONES = 8'hc0;
   localparam logic [7:0] LSEB_GP_WR_MASK    = 8'h3f;

   // Widths
   localparam int         LSEB_CODE_W  = 7;
   localparam int         LSEB_LEVEL_W = 16;
   localparam int         LSEB_CNT_W   = 24;

   // Exponential curve: octaves per code step in 1/256 units
   localparam logic [11:0] LSEB_EXP_SLOPE = 12'h013;

   // Ramp dwell times per code
   localparam int LSEB_CLK_PERIOD_NS  = 4;
   localparam int LSEB_STEP_FAST_NS   = 12750;
   localparam int LSEB_STEP_MID_NS    = 3250000;
   localparam int LSEB_STEP_SLOW_NS   = 6500000;
   localparam int LSEB_STEP_LONG_NS   = 13000000;
   localparam int LSEB_STEP_FAST_CYC  =
      (LSEB_STEP_FAST_NS + LSEB_CLK_PERIOD_NS - 1) / LSEB_CLK_PERIOD_NS;
   localparam int LSEB_STEP_MID_CYC   =
      (LSEB_STEP_MID_NS + LSEB_CLK_PERIOD_NS - 1) / LSEB_CLK_PERIOD_NS;
   localparam int LSEB_STEP_SLOW_CYC  =
      (LSEB_STEP_SLOW_NS + LSEB_CLK_PERIOD_NS - 1) / LSEB_CLK_PERIOD_NS;
   localparam int LSEB_STEP_LONG_CYC  =
      (LSEB_STEP_LONG_NS + LSEB_CLK_PERIOD_NS - 1) / LSEB_CLK_PERIOD_NS;

   // Serial port states, Gray along the usual write path
   typedef enum logic [3:0] {
      LSEB_IDLE     = 4'h0,
      LSEB_ADDR     = 4'h1,
      LSEB_ACK_ADDR = 4'h3,
      LSEB_REG      = 4'h2,
      LSEB_ACK_REG  = 4'h6,
      LSEB_WDATA    = 4'h7,
      LSEB_ACK_W    = 4'h5,
      LSEB_RDATA    = 4'h4,
      LSEB_RACK     = 4'hc
   } lseb_state_e;

endpackage

// *** verilog/lseb_led_sink_ctrl.sv ***
// Sink enable decode, brightness ramps and serial register port of a dual LED driver.
// Assumes scl/sda arrive asynchronously from pins; sda is open drain, resolved outside.
// What this block does
// - Unison, main on: both sinks at main code
// - Unison, main off: both sinks off
// - Only secondary on: secondary sink at secondary code
// - Only main on: main sink at main code
// - Both on: each sink at own code
// - Display mode, main on: feedback, main sink on
// - Display mode, main off: feedback, both sinks off
// - Analog power when any enable or display
// - Unison clear: independent currents per register
// - Brightness registers 8 bits, 7 bits used
// - Brightness top bit ignored for current
// - Rising codes give exponential current rise
// - Unison set: main register sets both
// - Code zero gives zero, monotonic rising table
// - Main brightness register at address 0xa0
// - Control bits 0,1,2 and 5 placed
// - Ramp one code per selectable dwell time
`timescale 1ns/1ps

module lseb_led_sink_ctrl
   import lseb_pkg::*;
#(
   parameter int STEP_MID_CYC  = LSEB_STEP_MID_CYC,
   parameter int STEP_SLOW_CYC = LSEB_STEP_SLOW_CYC,
   parameter int STEP_LONG_CYC = LSEB_STEP_LONG_CYC
) (
   // Clock and reset
   input  wire logic                    clk_in,
   input  wire logic                    sys_rst_in,
   // Serial register port pins
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output      logic                    sda_out,
   output      logic                    sda_oe_out,
   // Sink control
   output      logic                    main_sink_on_out,
   output      logic                    secondary_sink_on_out,
   output      logic                    secondary_sink_or_feedback_out,
   output      logic                    analog_power_out,
   output      logic [LSEB_LEVEL_W-1:0] main_level_out,
   output      logic [LSEB_LEVEL_W-1:0] secondary_level_out
);

   // Exponential map: linear mantissa on a base-two exponent
   function automatic logic [LSEB_LEVEL_W-1:0] lseb_exp(input logic [LSEB_CODE_W-1:0] c);
      logic [11:0] x;
      logic [17:0] v;
      x = 12'(c) * LSEB_EXP_SLOPE;
      v = 18'({1'b1, x[7:0]}) << x[11:8];
      return (c == 7'h00) ? 16'h0000 : v[17:2];
   endfunction

   logic [2:0]              scl_sync;
   logic [2:0]              sda_sync;
   logic                    scl_f;
   logic                    sda_f;
   logic                    scl_q;
   logic                    sda_q;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    bus_start;
   logic                    bus_stop;
   lseb_state_e             state;
   logic [3:0]              bit_cnt;
   logic [7:0]              shreg;
   logic [7:0]              outsh;
   logic [7:0]              ptr;
   logic                    rd_mode;
   logic                    nack;
   logic                    drive_low;
   logic                    wr_stb;
   logic [7:0]              rd_data;
   logic [7:0]              gp;
   logic [7:0]              main_brightness_level;
   logic [7:0]              secondary_brightness_level;
   logic                    main_sink_on;
   logic                    secondary_sink_on;
   logic                    shared_level_select;
   logic                    display_supply_mode;
   logic                    ramp_rate_low;
   logic                    ramp_rate_high;
   logic                    main_en;
   logic                    sec_en;
   logic [LSEB_CNT_W-1:0]   step_cyc;
   logic [LSEB_CODE_W-1:0]  want [2];
   logic [LSEB_CODE_W-1:0]  code [2];
   logic [LSEB_CODE_W-1:0]  goal [2];
   logic [LSEB_CNT_W-1:0]   dwell [2];

   // Pin synchronisers; a level counts once second and third stages agree
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[2] == scl_sync[1]) begin
            scl_f <= scl_sync[1];
         end
         if (sda_sync[2] == sda_sync[1]) begin
            sda_f <= sda_sync[1];
         end
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign scl_rise  = scl_f & ~scl_q;
   assign scl_fall  = ~scl_f & scl_q;
   assign bus_start = scl_f & scl_q & sda_q & ~sda_f;
   assign bus_stop  = scl_f & scl_q & ~sda_q & sda_f;

   // Open drain: only ever pull low
   assign sda_out    = 1'b0;
   assign sda_oe_out = drive_low;

   // Read mux; unmapped addresses read as zero
   always_comb begin
      case (ptr)
         LSEB_GP_ADDR:   rd_data = gp;
         LSEB_MAIN_ADDR: rd_data = main_brightness_level;
         LSEB_SEC_ADDR:  rd_data = secondary_brightness_level;
         default:        rd_data = LSEB_UNMAPPED;
      endcase
   end

   // Serial port sequencer: address, register pointer, then data bytes
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state     <= LSEB_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         outsh     <= 8'h00;
         ptr       <= 8'h00;
         rd_mode   <= 1'b0;
         nack      <= 1'b0;
         drive_low <= 1'b0;
         wr_stb    <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (bus_start) begin
            state     <= LSEB_ADDR;
            bit_cnt   <= 4'h0;
            drive_low <= 1'b0;
         end else if (bus_stop) begin
            state     <= LSEB_IDLE;
            drive_low <= 1'b0;
         end else if (scl_rise) begin
            if (state == LSEB_RACK) begin
               nack <= sda_f;
            end else begin
               shreg   <= {shreg[6:0], sda_f};
               bit_cnt <= bit_cnt + 4'h1;
            end
         end else if (scl_fall) begin
            case (state)
               LSEB_IDLE: begin
                  drive_low <= 1'b0;
               end
               LSEB_ADDR: begin
                  if (bit_cnt == 4'h8) begin
                     if (shreg[7:1] == LSEB_CHIP_ADDR) begin
                        state     <= LSEB_ACK_ADDR;
                        drive_low <= 1'b1;
                        rd_mode   <= shreg[0];
                     end else begin
                        state <= LSEB_IDLE;
                     end
                  end
               end
               LSEB_ACK_ADDR: begin
                  bit_cnt <= 4'h0;
                  if (rd_mode) begin
                     state     <= LSEB_RDATA;
                     outsh     <= rd_data;
                     drive_low <= ~rd_data[7];
                  end else begin
                     state     <= LSEB_REG;
                     drive_low <= 1'b0;
                  end
               end
               LSEB_REG: begin
                  if (bit_cnt == 4'h8) begin
                     state     <= LSEB_ACK_REG;
                     drive_low <= 1'b1;
                     ptr       <= shreg;
                  end
               end
               LSEB_ACK_REG, LSEB_ACK_W: begin
                  state     <= LSEB_WDATA;
                  bit_cnt   <= 4'h0;
                  drive_low <= 1'b0;
               end
               LSEB_WDATA: begin
                  if (bit_cnt == 4'h8) begin
                     state     <= LSEB_ACK_W;
                     drive_low <= 1'b1;
                     wr_stb    <= 1'b1;
                  end
               end
               LSEB_RDATA: begin
                  if (bit_cnt == 4'h8) begin
                     state     <= LSEB_RACK;
                     drive_low <= 1'b0;
                  end else begin
                     drive_low <= ~outsh[6];
                     outsh     <= {outsh[6:0], 1'b0};
                  end
               end
               LSEB_RACK: begin
                  bit_cnt <= 4'h0;
                  if (nack) begin
                     state <= LSEB_IDLE;
                  end else begin
                     state     <= LSEB_RDATA;
                     outsh     <= rd_data;
                     drive_low <= ~rd_data[7];
                  end
               end
               default: begin
                  state     <= LSEB_IDLE;
                  drive_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // Register file; shreg still holds the data byte during wr_stb
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         gp                         <= LSEB_GP_RESET;
         main_brightness_level      <= LSEB_LEVEL_RESET;
         secondary_brightness_level <= LSEB_LEVEL_RESET;
      end else if (wr_stb) begin
         case (ptr)
            LSEB_GP_ADDR: begin
               gp <= (shreg & LSEB_GP_WR_MASK) | LSEB_GP_FIXED_ONES;
            end
            LSEB_MAIN_ADDR: begin
               main_brightness_level <= shreg;
            end
            LSEB_SEC_ADDR: begin
               secondary_brightness_level <= shreg;
            end
            default: begin
               gp <= gp;
            end
         endcase
      end
   end

   assign main_sink_on        = gp[LSEB_MAIN_ON_BIT];
   assign secondary_sink_on   = gp[LSEB_SEC_ON_BIT];
   assign shared_level_select = gp[LSEB_SHARED_BIT];
   assign ramp_rate_low       = gp[LSEB_RAMP_LOW_BIT];
   assign ramp_rate_high      = gp[LSEB_RAMP_HIGH_BIT];
   assign display_supply_mode = gp[LSEB_DISPLAY_BIT];

   // main sink follows its own enable in every mode
   assign main_en = main_sink_on;
   // secondary enable, borrowed from main under unison
   assign sec_en  = ~display_supply_mode &
                    (shared_level_select ? main_sink_on : secondary_sink_on);

   // top bit dropped, disabled sinks ramp toward zero
   assign want[0] = main_en ? main_brightness_level[6:0] : 7'h00;
   assign want[1] = ~sec_en ? 7'h00 :
                    shared_level_select ? main_brightness_level[6:0] :
                                          secondary_brightness_level[6:0];

   always_comb begin
      case ({ramp_rate_low, ramp_rate_high})
         2'b00:   step_cyc = LSEB_CNT_W'(LSEB_STEP_FAST_CYC);
         2'b01:   step_cyc = LSEB_CNT_W'(STEP_MID_CYC);
         2'b10:   step_cyc = LSEB_CNT_W'(STEP_SLOW_CYC);
         default: step_cyc = LSEB_CNT_W'(STEP_LONG_CYC);
      endcase
   end

   // a ramp runs to its latched goal before taking a new one
   for (genvar i = 0; i < 2; i++) begin : g_ramp
      always_ff @(posedge clk_in) begin
         if (sys_rst_in) begin
            code[i]  <= 7'h00;
            goal[i]  <= 7'h00;
            dwell[i] <= '0;
         end else if (code[i] == goal[i]) begin
            dwell[i] <= '0;
            if (want[i] != code[i]) begin
               goal[i] <= want[i];
               code[i] <= (want[i] > code[i]) ? code[i] + 7'h01 : code[i] - 7'h01;
            end
         end else if (dwell[i] >= step_cyc - 24'h000001) begin
            dwell[i] <= '0;
            code[i]  <= (goal[i] > code[i]) ? code[i] + 7'h01 : code[i] - 7'h01;
         end else begin
            dwell[i] <= dwell[i] + 24'h000001;
         end
      end
   end

   // Registered sink outputs
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         main_sink_on_out               <= 1'b0;
         secondary_sink_on_out          <= 1'b0;
         secondary_sink_or_feedback_out <= 1'b0;
         analog_power_out               <= 1'b0;
         main_level_out                 <= 16'h0000;
         secondary_level_out            <= 16'h0000;
      end else begin
         main_sink_on_out               <= main_en;
         secondary_sink_on_out          <= sec_en;
         secondary_sink_or_feedback_out <= display_supply_mode;
         analog_power_out <= main_sink_on | secondary_sink_on | display_supply_mode;
         // exponential current, zero when the sink is off
         main_level_out      <= main_en ? lseb_exp(code[0]) : 16'h0000;
         secondary_level_out <= sec_en ? lseb_exp(code[1]) : 16'h0000;
      end
   end

   property p_unison_on;
      @(posedge clk_in) disable iff (sys_rst_in)
      shared_level_select & ~display_supply_mode & main_sink_on
      |=> main_sink_on_out && secondary_sink_on_out;
   endproperty
   a_unison_on: assert property (p_unison_on) else $error("unison on wrong");

   property p_unison_off;
      @(posedge clk_in) disable iff (sys_rst_in)
      shared_level_select & ~display_supply_mode & ~main_sink_on
      |=> !main_sink_on_out && !secondary_sink_on_out;
   endproperty
   a_unison_off: assert property (p_unison_off) else $error("unison off wrong");

   property p_sec_only;
      @(posedge clk_in) disable iff (sys_rst_in)
      ~shared_level_select & ~display_supply_mode & ~main_sink_on & secondary_sink_on
      |=> !main_sink_on_out && secondary_sink_on_out;
   endproperty
   a_sec_only: assert property (p_sec_only) else $error("secondary only wrong");

   property p_main_only;
      @(posedge clk_in) disable iff (sys_rst_in)
      ~shared_level_select & ~display_supply_mode & main_sink_on & ~secondary_sink_on
      |=> main_sink_on_out && !secondary_sink_on_out;
   endproperty
   a_main_only: assert property (p_main_only) else $error("main only wrong");

   property p_both;
      @(posedge clk_in) disable iff (sys_rst_in)
      ~shared_level_select & ~display_supply_mode & main_sink_on & secondary_sink_on
      |=> main_sink_on_out && secondary_sink_on_out;
   endproperty
   a_both: assert property (p_both) else $error("both sinks wrong");

   property p_disp;
      @(posedge clk_in) disable iff (sys_rst_in)
      display_supply_mode |=> secondary_sink_or_feedback_out && !secondary_sink_on_out
                              && (main_sink_on_out == $past(main_sink_on));
   endproperty
   a_disp: assert property (p_disp) else $error("display mode wrong");

   property p_power;
      @(posedge clk_in) disable iff (sys_rst_in)
      ##1 analog_power_out == $past(main_sink_on | secondary_sink_on | display_supply_mode);
   endproperty
   a_power: assert property (p_power) else $error("analog power wrong");

   property p_shared_src;
      @(posedge clk_in) disable iff (sys_rst_in)
      shared_level_select & sec_en |-> want[1] == want[0];
   endproperty
   a_shared_src: assert property (p_shared_src) else $error("unison source wrong");

   property p_one_step;
      @(posedge clk_in) disable iff (sys_rst_in)
      code[0] != $past(code[0]) |->
         (code[0] == $past(code[0]) + 7'h01) || (code[0] == $past(code[0]) - 7'h01);
   endproperty
   a_one_step: assert property (p_one_step) else $error("ramp skipped a code");

   property p_zero_level;
      @(posedge clk_in) disable iff (sys_rst_in)
      code[0] == 7'h00 |=> main_level_out == 16'h0000;
   endproperty
   a_zero_level: assert property (p_zero_level) else $error("code zero not zero");

   property p_sec_kept;
      @(posedge clk_in) disable iff (sys_rst_in)
      !(wr_stb && ptr == LSEB_SEC_ADDR) |=> $stable(secondary_brightness_level);
   endproperty
   a_sec_kept: assert property (p_sec_kept) else $error("secondary level changed");

   c_unison:  cover property (@(posedge clk_in) secondary_sink_on_out && shared_level_select);
   c_display: cover property (@(posedge clk_in) secondary_sink_or_feedback_out && main_sink_on_out);
   c_full:    cover property (@(posedge clk_in) code[0] == 7'h7f);
   c_read:    cover property (@(posedge clk_in) state == LSEB_RACK);

endmodule

// *** testbench/lseb_host_model.sv ***
// Host model: two-wire serial bus master for the register port.
// Assumes an open-drain data line with pull-up, resolved by the bench.
`timescale 1ns/1ps

module lseb_host_model
   import lseb_pkg::*;
#(
   parameter int HALF = 10
) (
   // Clock and resolved line
   input  wire logic clk_in,
   input  wire logic sda_in,
   // Driven pins, 1 on sda means released
   output      logic scl_out,
   output      logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Also serves as repeated start
   task automatic start_c();
      tick(2);
      sda_out = 1'b1;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      sda_out = 1'b0;
      tick(HALF);
      scl_out = 1'b0;
   endtask

   task automatic stop_c();
      tick(2);
      sda_out = 1'b0;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF);
      sda_out = 1'b1;
      tick(HALF);
   endtask

   // Data moves 2 clk after scl fall, never while scl is high
   task automatic bit_c(input logic b, output logic seen);
      tick(2);
      sda_out = b;
      tick(HALF);
      scl_out = 1'b1;
      tick(HALF / 2);
      seen = sda_in;
      tick(HALF / 2);
      scl_out = 1'b0;
   endtask

   task automatic byte_c(input logic [7:0] b, output logic [7:0] seen, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(b[i], s);
         seen[i] = s;
      end
      bit_c(1'b1, s);
      ack = ~s;
   endtask

   task automatic write_reg(input logic [7:0] ra, input logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       a0, a1, a2;
      start_c();
      byte_c({LSEB_CHIP_ADDR, 1'b0}, x, a0);
      byte_c(ra, x, a1);
      byte_c(d, x, a2);
      stop_c();
      ok = a0 & a1 & a2;
   endtask

   // Single byte read, always ended by a nack
   task automatic read_reg(input logic [7:0] ra, output logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       a0, a1, a2, nk;
      start_c();
      byte_c({LSEB_CHIP_ADDR, 1'b0}, x, a0);
      byte_c(ra, x, a1);
      start_c();
      byte_c({LSEB_CHIP_ADDR, 1'b1}, x, a2);
      byte_c(8'hff, d, nk);
      stop_c();
      ok = a0 & a1 & a2;
   endtask

   task automatic probe(input logic [6:0] ca, output logic ok);
      logic [7:0] x;
      start_c();
      byte_c({ca, 1'b0}, x, ok);
      stop_c();
   endtask
endmodule

// *** testbench/lseb_led_sink_ctrl_test.sv ***
// Self-checking bench for the LED sink enable and brightness block.
// Assumes the host model as register master on a pulled-up data line.
`timescale 1ns/1ps

module lseb_led_sink_ctrl_test
   import lseb_pkg::*;
();
   localparam int         STEP  = 40;
   localparam logic [7:0] RA[4] = '{LSEB_GP_ADDR, LSEB_MAIN_ADDR, LSEB_SEC_ADDR, 8'h20};
   localparam logic [7:0] RV[4] = '{8'hc0, 8'h80, 8'h80, 8'h00};
   // Clock, reset and pins
   logic        clk_in     = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        scl, sda_rel, sda_line, sda_out, sda_oe_out;
   // Sink outputs
   logic        main_on, sec_on, fb_on, pwr_on;
   logic [15:0] main_lvl, sec_lvl;
   int          errors     = 0;
   int          n_tests    = 0;

   always #2 clk_in = ~clk_in;
   assign sda_line = sda_rel & ~(sda_oe_out & ~sda_out);

   lseb_host_model #(.HALF(10)) lseb_host_model_inst (
      .clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_out(sda_rel));

   lseb_led_sink_ctrl #(.STEP_MID_CYC(STEP), .STEP_SLOW_CYC(60), .STEP_LONG_CYC(80))
   lseb_led_sink_ctrl_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .main_sink_on_out(main_on),
      .secondary_sink_on_out(sec_on), .secondary_sink_or_feedback_out(fb_on),
      .analog_power_out(pwr_on), .main_level_out(main_lvl), .secondary_level_out(sec_lvl));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Same curve as the level map, only the low 7 bits count
   function automatic logic [15:0] exp_level(input logic [7:0] r);
      logic [11:0] x;
      logic [31:0] v;
      x = 12'(r[6:0]) * LSEB_EXP_SLOPE;
      v = (32'({1'b1, x[7:0]}) << x[11:8]) >> 2;
      return (r[6:0] == 7'h00) ? 16'h0000 : v[15:0];
   endfunction

   // Returns power, feedback, secondary on, main on
   function automatic logic [3:0] exp_sinks(input logic [7:0] g);
      logic s;
      s = g[5] ? 1'b0 : (g[2] ? g[0] : g[1]);
      return {g[0] | g[1] | g[5], g[5], s, g[0]};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      lseb_host_model_inst.write_reg(a, d, ok);
      check({15'h0000, ok}, 16'h0001);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      lseb_host_model_inst.read_reg(a, d, ok);
      check({7'h00, ok, d}, {8'h01, e});
   endtask

   // Ramps may pass an old latched goal first, so the bound covers two sweeps
   task automatic wait_lvl(input logic [15:0] em, input logic [15:0] es);
      int n;
      n = 0;
      while ((main_lvl !== em || sec_lvl !== es) && n < 12000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      check(main_lvl, em);
      check(sec_lvl, es);
      if (n >= 12000) report_and_stop();
   endtask

   initial begin
      logic [7:0] m, s, g;
      logic [3:0] e;
      logic       ok;
      void'($urandom(32'h854aba42));
      repeat (5) @(posedge clk_in);
      #1;
      sys_rst_in = 1'b0;
      repeat (4) @(posedge clk_in);
      #1;
      check({12'h000, main_on, sec_on, fb_on, pwr_on}, 16'h0000);
      for (int i = 0; i < 4; i++) rd(RA[i], RV[i]);
      lseb_host_model_inst.probe(LSEB_CHIP_ADDR ^ 7'h01, ok);
      check({15'h0000, ok}, 16'h0000);
      m = {1'($urandom()), 7'($urandom_range(1, 24))};
      s = {1'($urandom()), 7'($urandom_range(25, 40))};
      wr(LSEB_MAIN_ADDR, m);
      wr(LSEB_SEC_ADDR, s);
      for (int k = 0; k < 16; k++) begin
         g = {2'b00, k[3], 2'b10, k[2:0]};
         e = exp_sinks(g);
         wr(LSEB_GP_ADDR, g);
         repeat (3) @(posedge clk_in);
         #1;
         check({12'h000, pwr_on, fb_on, sec_on, main_on}, {12'h000, e});
         wait_lvl(g[0] ? exp_level(m) : 16'h0000, e[1] ? exp_level(g[2] ? m : s) : 16'h0000);
         rd(LSEB_GP_ADDR, g | LSEB_GP_FIXED_ONES);
      end
      wr(LSEB_GP_ADDR, 8'h17);
      wait_lvl(exp_level(m), exp_level(m));
      rd(LSEB_SEC_ADDR, s);
      wr(LSEB_GP_ADDR, 8'h13);
      wait_lvl(exp_level(m), exp_level(s));
      wr(LSEB_MAIN_ADDR, 8'hff);
      rd(LSEB_MAIN_ADDR, 8'hff);
      wait_lvl(exp_level(8'h7f), exp_level(s));
      wr(LSEB_MAIN_ADDR, 8'h80);
      wait_lvl(16'h0000, exp_level(s));
      check({15'h0000, main_on}, 16'h0001);
      wr(LSEB_GP_ADDR, 8'h19);
      wr(LSEB_MAIN_ADDR, 8'h0a);
      check({15'h0000, main_lvl === exp_level(8'h0a)}, 16'h0000);
      repeat (160) @(posedge clk_in);
      #1;
      check({15'h0000, main_lvl > exp_level(8'h01) && main_lvl < exp_level(8'h0a)}, 16'h0001);
      wait_lvl(exp_level(8'h0a), 16'h0000);
      report_and_stop();
   end
endmodule
